// >>> rtl/smbc_pkg.sv
package smbc_pkg;

  // Core clock.
  localparam int CLK_PERIOD_NS = 25;

  // Pin filter: pulses up to the spike width are rejected.
  localparam int SPIKE_NS = 50;
  localparam int FILT_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Clock-low time-out, a least time so it rounds up.
  localparam int TIMEOUT_MS  = 30;
  localparam int TIMEOUT_CYC = (TIMEOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus-idle reset, a least time so it rounds up.
  localparam int IDLE_US  = 150;
  localparam int IDLE_CYC = (IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host bus clock period; each bit is four quarters.
  localparam int HOST_SCL_NS  = 10000;
  localparam int HOST_QTR_CYC = HOST_SCL_NS / 4 / CLK_PERIOD_NS;

  // Byte framing: eight data bits, then the acknowledge bit.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Strap capture waits this many cycles for the strap synchroniser.
  localparam logic [1:0] STRAP_WAIT = 2'h3;

  // Alert response address and the strap-selected client addresses.
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [6:0] STRAP_ADDR [8] = '{7'h4C, 7'h4D, 7'h4E, 7'h4F,
                                            7'h49, 7'h4A, 7'h4B, 7'h18};

  // Client states, Gray along idle, address, acknowledge, data.
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_ADDR = 3'h1,
    DS_AACK = 3'h3,
    DS_RX   = 3'h2,
    DS_DACK = 3'h6,
    DS_TX   = 3'h7,
    DS_HACK = 3'h5,
    DS_SKIP = 3'h4
  } smbc_dev_state_e;

  // Host states.
  typedef enum logic [1:0] {
    HS_IDLE  = 2'h0,
    HS_START = 2'h1,
    HS_XFER  = 2'h3,
    HS_STOP  = 2'h2
  } smbc_host_state_e;

  // Host command codes.
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ  = 2'h2;
  localparam logic [1:0] CMD_STOP  = 2'h3;

endpackage : smbc_pkg

// >>> rtl/smbc_bus_if.sv
`timescale 1ns/100ps
interface smbc_bus_if;
  // Host drives the clock line; both ends may pull the data line low.
  logic hostSclOut;
  logic hostSclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic sclLevel;
  logic sdaLevel;

  // Open-drain wires with pull-ups: any enabled low driver wins.
  assign sclLevel = !(hostSclOe && !hostSclOut);
  assign sdaLevel = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

  modport device (input sclLevel, input sdaLevel, output devSdaOut, output devSdaOe);
  modport host (input sclLevel, input sdaLevel, output hostSclOut, output hostSclOe,
                output hostSdaOut, output hostSdaOe);
endinterface : smbc_bus_if

// >>> rtl/smbc_device.sv
`timescale 1ns/100ps
module smbc_device
  import smbc_pkg::*;
#(
  parameter int TimeoutCyc = TIMEOUT_CYC,
  parameter int IdleCyc    = IDLE_CYC,
  parameter int FiltCyc    = FILT_CYC
) (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Two-wire bus.
  smbc_bus_if.device      bus,
  // Strap and configuration.
  input  wire logic [2:0] addrSel,
  input  wire logic       alertActive,
  input  wire logic       timeoutEn,
  input  wire logic       idleResetEn,
  // Transmit data.
  input  wire logic [7:0] txByte,
  output logic            txTaken,
  // Receive data.
  output logic [7:0]      rxByte,
  output logic            rxValid,
  // Status.
  output logic            selected,
  output logic            readDir,
  output logic            araAnswered,
  output logic            busReset
);

  localparam int FCW = $clog2(FiltCyc + 1);
  localparam int TCW = $clog2(TimeoutCyc + 1);
  localparam int ICW = $clog2(IdleCyc + 1);

  // Refuse parameters the counters cannot serve.
  if (FiltCyc < 1 || TimeoutCyc < 2 || IdleCyc < 2) begin : g_badParam
    $error("smbc_device: parameter out of range");
  end

  // Pin synchronisers; the first stage feeds only the second.
  logic [1:0] pinMeta_q;
  logic [1:0] pinSync_q;
  logic [2:0] strapMeta_q;
  logic [2:0] strapSync_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q   <= 2'h3;
      pinSync_q   <= 2'h3;
      strapMeta_q <= 3'h0;
      strapSync_q <= 3'h0;
    end else begin
      pinMeta_q   <= {bus.sclLevel, bus.sdaLevel};
      pinSync_q   <= pinMeta_q;
      strapMeta_q <= addrSel;
      strapSync_q <= strapMeta_q;
    end
  end

  // Glitch filter: a new level must hold for FiltCyc samples before it is seen.
  logic           filt_q [2];
  logic           filt_d [2];
  logic [FCW-1:0] stab_q [2];
  logic [FCW-1:0] stab_d [2];
  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_comb begin
      filt_d[i] = filt_q[i];
      stab_d[i] = '0;
      if (pinSync_q[i] != filt_q[i]) begin
        stab_d[i] = stab_q[i] + 1'b1;
        if (stab_q[i] == FCW'(FiltCyc - 1)) begin
          filt_d[i] = pinSync_q[i];
          stab_d[i] = '0;
        end
      end
    end
    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        filt_q[i] <= 1'b1;
        stab_q[i] <= '0;
      end else begin
        filt_q[i] <= filt_d[i];
        stab_q[i] <= stab_d[i];
      end
    end
  end

  // Filtered levels and their edges.
  logic sclF;
  logic sdaF;
  logic sclP_q;
  logic sdaP_q;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  assign sclF      = filt_q[1];
  assign sdaF      = filt_q[0];
  assign sclRise   = sclF && !sclP_q;
  assign sclFall   = !sclF && sclP_q;
  assign startCond = sclF && sclP_q && sdaP_q && !sdaF;
  assign stopCond  = sclF && sclP_q && !sdaP_q && sdaF;

  // Client state.
  smbc_dev_state_e state_q, state_d;
  logic [3:0]      bitCnt_q, bitCnt_d;
  logic [7:0]      shift_q, shift_d;
  logic [7:0]      rxByte_q, rxByte_d;
  logic [6:0]      ownAddr_q, ownAddr_d;
  logic [1:0]      strapCnt_q, strapCnt_d;
  logic [TCW-1:0]  lowCnt_q, lowCnt_d;
  logic [ICW-1:0]  highCnt_q, highCnt_d;
  logic            sdaOe_q, sdaOe_d;
  logic            readDir_q, readDir_d;
  logic            selected_q, selected_d;
  logic            ara_q, ara_d;
  logic            rxValid_q, rxValid_d;
  logic            txTaken_q, txTaken_d;
  logic            araAns_q, araAns_d;
  logic            busReset_q, busReset_d;
  logic            toEn_q;
  logic            idleEn_q;
  logic            sdaOut_q;
  logic            toFire;
  logic            idleFire;
  logic            addrHit;
  logic            araHit;
  logic [7:0]      loadByte;

  // A saturated count fires only while its bus condition still holds, so a start that ends
  // a long idle spell is not swallowed by the idle reset.
  assign toFire   = lowCnt_q == TCW'(TimeoutCyc) && !sclF;
  assign idleFire = highCnt_q == ICW'(IdleCyc) && sclF && sdaF;
  assign addrHit  = shift_q[7:1] == ownAddr_q;
  assign araHit   = shift_q[7:1] == ARA_ADDR && shift_q[0] && alertActive;
  assign loadByte = ara_q ? {ownAddr_q, 1'b0} : txByte;

  // Next-state logic: resets and bus conditions take priority over bit handling.
  always_comb begin
    state_d    = state_q;
    bitCnt_d   = bitCnt_q;
    shift_d    = shift_q;
    sdaOe_d    = sdaOe_q;
    readDir_d  = readDir_q;
    selected_d = selected_q;
    ara_d      = ara_q;
    rxByte_d   = rxByte_q;
    rxValid_d  = 1'b0;
    txTaken_d  = 1'b0;
    araAns_d   = 1'b0;
    busReset_d = 1'b0;
    ownAddr_d  = ownAddr_q;
    strapCnt_d = strapCnt_q;
    // The strap is sampled only after release, once the synchroniser holds it.
    if (strapCnt_q != STRAP_WAIT) begin
      strapCnt_d = strapCnt_q + 2'h1;
      ownAddr_d  = STRAP_ADDR[strapSync_q];
    end
    // Counters saturate so a stuck bus keeps the client parked in idle.
    lowCnt_d  = '0;
    highCnt_d = '0;
    if (toEn_q && !sclF) begin
      lowCnt_d = toFire ? lowCnt_q : lowCnt_q + 1'b1;
    end
    if (idleEn_q && sclF && sdaF) begin
      highCnt_d = idleFire ? highCnt_q : highCnt_q + 1'b1;
    end
    if (toFire || idleFire) begin
      busReset_d = state_q != DS_IDLE;
      state_d    = DS_IDLE;
      sdaOe_d    = 1'b0;
      selected_d = 1'b0;
    end else if (startCond) begin
      state_d    = DS_ADDR;
      bitCnt_d   = '0;
      sdaOe_d    = 1'b0;
      selected_d = 1'b0;
      ara_d      = 1'b0;
    end else if (stopCond) begin
      state_d    = DS_IDLE;
      sdaOe_d    = 1'b0;
      selected_d = 1'b0;
    end else begin
      unique case (state_q)
        DS_IDLE, DS_SKIP: begin
        end
        DS_ADDR, DS_RX: begin
          if (sclRise && bitCnt_q != BYTE_BITS) begin
            shift_d  = {shift_q[6:0], sdaF};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == BYTE_BITS) begin
            bitCnt_d = '0;
            if (state_q == DS_RX) begin
              rxByte_d  = shift_q;
              rxValid_d = 1'b1;
              sdaOe_d   = 1'b1;
              state_d   = DS_DACK;
            end else if (addrHit || araHit) begin
              state_d    = DS_AACK;
              sdaOe_d    = 1'b1;
              readDir_d  = shift_q[0];
              selected_d = 1'b1;
              ara_d      = araHit;
            end else begin
              state_d = DS_SKIP;
            end
          end
        end
        DS_AACK, DS_DACK: begin
          if (sclFall) begin
            sdaOe_d = 1'b0;
            state_d = DS_RX;
            if (state_q == DS_AACK && readDir_q) begin
              state_d   = DS_TX;
              shift_d   = loadByte;
              sdaOe_d   = !loadByte[7];
              txTaken_d = !ara_q;
            end
          end
        end
        DS_TX: begin
          if (sclRise) begin
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall) begin
            if (bitCnt_q == BYTE_BITS) begin
              sdaOe_d  = 1'b0;
              state_d  = DS_HACK;
              araAns_d = ara_q;
            end else begin
              shift_d = {shift_q[6:0], 1'b0};
              sdaOe_d = !shift_q[6];
            end
          end
        end
        DS_HACK: begin
          if (sclRise) begin
            shift_d[0] = sdaF;
          end else if (sclFall) begin
            if (shift_q[0] || ara_q) begin
              state_d = DS_SKIP;
            end else begin
              state_d   = DS_TX;
              bitCnt_d  = '0;
              shift_d   = loadByte;
              sdaOe_d   = !loadByte[7];
              txTaken_d = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Register stage; enables reset to off so both resets start disabled.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= DS_IDLE;
      bitCnt_q   <= '0;
      shift_q    <= '0;
      sdaOe_q    <= 1'b0;
      readDir_q  <= 1'b0;
      selected_q <= 1'b0;
      ara_q      <= 1'b0;
      rxByte_q   <= '0;
      rxValid_q  <= 1'b0;
      txTaken_q  <= 1'b0;
      araAns_q   <= 1'b0;
      busReset_q <= 1'b0;
      ownAddr_q  <= '0;
      strapCnt_q <= '0;
      lowCnt_q   <= '0;
      highCnt_q  <= '0;
      toEn_q     <= 1'b0;
      idleEn_q   <= 1'b0;
      sclP_q     <= 1'b1;
      sdaP_q     <= 1'b1;
      sdaOut_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      bitCnt_q   <= bitCnt_d;
      shift_q    <= shift_d;
      sdaOe_q    <= sdaOe_d;
      readDir_q  <= readDir_d;
      selected_q <= selected_d;
      ara_q      <= ara_d;
      rxByte_q   <= rxByte_d;
      rxValid_q  <= rxValid_d;
      txTaken_q  <= txTaken_d;
      araAns_q   <= araAns_d;
      busReset_q <= busReset_d;
      ownAddr_q  <= ownAddr_d;
      strapCnt_q <= strapCnt_d;
      lowCnt_q   <= lowCnt_d;
      highCnt_q  <= highCnt_d;
      toEn_q     <= timeoutEn;
      idleEn_q   <= idleResetEn;
      sclP_q     <= sclF;
      sdaP_q     <= sdaF;
      sdaOut_q   <= 1'b0;
    end
  end

  // Only the data line is ever pulled; the clock is never held low.
  assign bus.devSdaOut = sdaOut_q;
  assign bus.devSdaOe  = sdaOe_q;
  assign txTaken       = txTaken_q;
  assign rxByte        = rxByte_q;
  assign rxValid       = rxValid_q;
  assign selected      = selected_q;
  assign readDir       = readDir_q;
  assign araAnswered   = araAns_q;
  assign busReset      = busReset_q;

endmodule : smbc_device

// >>> rtl/smbc_host.sv
`timescale 1ns/100ps
module smbc_host
  import smbc_pkg::*;
#(
  parameter int QtrCyc = HOST_QTR_CYC
) (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Two-wire bus.
  smbc_bus_if.host        bus,
  // Command.
  input  wire logic       cmdValid,
  input  wire logic [1:0] cmdKind,
  input  wire logic [7:0] cmdByte,
  input  wire logic       cmdNack,
  output logic            cmdReady,
  // Response.
  output logic            rspValid,
  output logic [7:0]      rspByte,
  output logic            rspNack
);

  localparam int QCW = $clog2(QtrCyc + 1);

  // Quarters must outlast the client's synchroniser and filter.
  if (QtrCyc < 8) begin : g_badParam
    $error("smbc_host: QtrCyc too small");
  end

  // Bus synchronisers.
  logic sclMeta_q;
  logic sclSync_q;
  logic sdaMeta_q;
  logic sdaSync_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
    end else begin
      sclMeta_q <= bus.sclLevel;
      sclSync_q <= sclMeta_q;
      sdaMeta_q <= bus.sdaLevel;
      sdaSync_q <= sdaMeta_q;
    end
  end

  smbc_host_state_e state_q, state_d;
  logic [QCW-1:0]   qCnt_q, qCnt_d;
  logic [1:0]       qIdx_q, qIdx_d;
  logic [3:0]       bitIdx_q, bitIdx_d;
  logic [7:0]       shift_q, shift_d;
  logic [7:0]       rspByte_q, rspByte_d;
  logic             read_q, read_d;
  logic             nack_q, nack_d;
  logic             held_q, held_d;
  logic             sclOe_q, sclOe_d;
  logic             sdaOe_q, sdaOe_d;
  logic             ready_q, ready_d;
  logic             rspValid_q, rspValid_d;
  logic             rspNack_q, rspNack_d;
  logic             lowOut_q;
  logic             stall;
  logic             tick;

  // A released clock still seen low means someone stretches it; wait.
  assign stall = state_q != HS_IDLE && !sclOe_q && !sclSync_q;
  assign tick  = qCnt_q == QCW'(QtrCyc - 1) && !stall;

  // Each bit: quarter 0 low, 1 low with data set, 2 and 3 high, sampled at 2's end.
  always_comb begin
    state_d    = state_q;
    qCnt_d     = (state_q == HS_IDLE || tick) ? '0 : (stall ? qCnt_q : qCnt_q + 1'b1);
    qIdx_d     = tick ? qIdx_q + 2'h1 : qIdx_q;
    bitIdx_d   = bitIdx_q;
    shift_d    = shift_q;
    rspByte_d  = rspByte_q;
    read_d     = read_q;
    nack_d     = nack_q;
    held_d     = held_q;
    sclOe_d    = sclOe_q;
    sdaOe_d    = sdaOe_q;
    ready_d    = ready_q;
    rspValid_d = 1'b0;
    rspNack_d  = rspNack_q;
    unique case (state_q)
      HS_IDLE: begin
        qIdx_d = '0;
        if (cmdValid && ready_q) begin
          bitIdx_d = '0;
          if (cmdKind == CMD_START) begin
            state_d = HS_START;
            sdaOe_d = 1'b0;
            ready_d = 1'b0;
          end else if (cmdKind == CMD_STOP && held_q) begin
            state_d = HS_STOP;
            ready_d = 1'b0;
          end else if (cmdKind != CMD_STOP && held_q) begin
            state_d = HS_XFER;
            ready_d = 1'b0;
            read_d  = cmdKind == CMD_READ;
            nack_d  = cmdNack;
            shift_d = cmdByte;
          end
        end
      end
      HS_START: begin
        if (tick) begin
          unique case (qIdx_q)
            2'h0: sclOe_d = 1'b0;
            2'h1: sdaOe_d = 1'b1;
            2'h2: sclOe_d = 1'b0;
            2'h3: begin
              sclOe_d = 1'b1;
              held_d  = 1'b1;
              ready_d = 1'b1;
              state_d = HS_IDLE;
            end
          endcase
        end
      end
      HS_XFER: begin
        if (tick) begin
          unique case (qIdx_q)
            2'h0: begin
              if (bitIdx_q == BYTE_BITS) begin
                sdaOe_d = read_q && !nack_q;
              end else begin
                sdaOe_d = !read_q && !shift_q[7];
              end
            end
            2'h1: sclOe_d = 1'b0;
            2'h2: begin
              if (bitIdx_q == BYTE_BITS) begin
                rspNack_d = sdaSync_q;
              end else begin
                shift_d = {shift_q[6:0], sdaSync_q};
              end
            end
            2'h3: begin
              sclOe_d  = 1'b1;
              bitIdx_d = bitIdx_q + 4'h1;
              if (bitIdx_q == BYTE_BITS) begin
                state_d    = HS_IDLE;
                ready_d    = 1'b1;
                rspValid_d = 1'b1;
                rspByte_d  = shift_q;
              end
            end
          endcase
        end
      end
      HS_STOP: begin
        if (tick) begin
          unique case (qIdx_q)
            2'h0: sdaOe_d = 1'b1;
            2'h1: sclOe_d = 1'b0;
            2'h2: sdaOe_d = 1'b0;
            2'h3: begin
              held_d  = 1'b0;
              ready_d = 1'b1;
              state_d = HS_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  // Register stage.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= HS_IDLE;
      qCnt_q     <= '0;
      qIdx_q     <= '0;
      bitIdx_q   <= '0;
      shift_q    <= '0;
      rspByte_q  <= '0;
      read_q     <= 1'b0;
      nack_q     <= 1'b0;
      held_q     <= 1'b0;
      sclOe_q    <= 1'b0;
      sdaOe_q    <= 1'b0;
      ready_q    <= 1'b1;
      rspValid_q <= 1'b0;
      rspNack_q  <= 1'b0;
      lowOut_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      qCnt_q     <= qCnt_d;
      qIdx_q     <= qIdx_d;
      bitIdx_q   <= bitIdx_d;
      shift_q    <= shift_d;
      rspByte_q  <= rspByte_d;
      read_q     <= read_d;
      nack_q     <= nack_d;
      held_q     <= held_d;
      sclOe_q    <= sclOe_d;
      sdaOe_q    <= sdaOe_d;
      ready_q    <= ready_d;
      rspValid_q <= rspValid_d;
      rspNack_q  <= rspNack_d;
      lowOut_q   <= 1'b0;
    end
  end

  // Open-drain drivers only ever pull low.
  assign bus.hostSclOut = lowOut_q;
  assign bus.hostSclOe  = sclOe_q;
  assign bus.hostSdaOut = lowOut_q;
  assign bus.hostSdaOe  = sdaOe_q;
  assign cmdReady       = ready_q;
  assign rspValid       = rspValid_q;
  assign rspByte        = rspByte_q;
  assign rspNack        = rspNack_q;

endmodule : smbc_host

// >>> verif/smbc_bus_props.sv
`timescale 1ns/100ps
// Watches the shared two-wire bus between the host end and the client end.
module smbc_bus_props (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Host drives.
  input wire logic hostSclOut,
  input wire logic hostSclOe,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  // Client drives.
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  // Resolved wire levels.
  input wire logic sclLevel,
  input wire logic sdaLevel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // A low clock always has the host behind it, since the client owns no clock driver.
  property p_sclOwner; !sclLevel |-> hostSclOe && !hostSclOut; endproperty
  a_sclOwner: assert property (p_sclOwner) else $error("clock low without host");

  // Both ends are open drain: an enabled driver only ever pulls low.
  property p_devOd; devSdaOe |-> !devSdaOut; endproperty
  a_devOd: assert property (p_devOd) else $error("client drives data high");
  property p_hostOd; hostSdaOe |-> !hostSdaOut; endproperty
  a_hostOd: assert property (p_hostOd) else $error("host drives data high");

  // The client moves its data drive 4 to 6 cycles after a clock fall, never elsewhere.
  property p_devEdge; $changed(devSdaOe) |-> $past(sclLevel, 7) && !$past(sclLevel, 4); endproperty
  a_devEdge: assert property (p_devEdge) else $error("client data moved off the fall");

  // A client change under a high clock would fake a start or a stop.
  property p_devQuiet; sclLevel && $past(sclLevel) |-> $stable(devSdaOe); endproperty
  a_devQuiet: assert property (p_devQuiet) else $error("client data moved while clock high");

  // Data edges under a high clock are start or stop, made only by the host.
  property p_sdaByHost; sclLevel && $changed(sdaLevel) |-> $changed(hostSdaOe); endproperty
  a_sdaByHost: assert property (p_sdaByHost) else $error("data edge in high clock not host");

  // Clock phases last long enough for the filtered client to see every bit.
  property p_sclHigh; $rose(sclLevel) |=> sclLevel [*8]; endproperty
  a_sclHigh: assert property (p_sclHigh) else $error("clock high phase too short");
  property p_sclLow; $fell(sclLevel) |=> !sclLevel [*8]; endproperty
  a_sclLow: assert property (p_sclLow) else $error("clock low phase too short");

  // Main events on the wire.
  c_ack: cover property (devSdaOe && $rose(sclLevel));
  c_start: cover property (sclLevel && $fell(sdaLevel));
  c_stop: cover property (sclLevel && $rose(sdaLevel));
endmodule : smbc_bus_props

// >>> verif/tb.sv
`timescale 1ns/100ps
// Host end and client end joined over the bus; the bench drives both user sides.
module tb;
  import smbc_pkg::*;
  // Shortened time-out keeps the run brief.
  localparam int ToCyc = 200;
  localparam logic [6:0] ADDR [8] = '{7'h4C, 7'h4D, 7'h4E, 7'h4F, 7'h49, 7'h4A, 7'h4B, 7'h18};
  logic       core_clk    = 1'b0;
  logic       resetn      = 1'b0;
  logic [2:0] addrSel     = 3'h0;
  logic       alertActive = 1'b0;
  logic       timeoutEn   = 1'b0;
  logic       idleResetEn = 1'b0;
  logic [7:0] txByte      = 8'hA5;
  logic       cmdValid    = 1'b0;
  logic [1:0] cmdKind     = 2'h0;
  logic [7:0] cmdByte     = 8'h00;
  logic       cmdNack     = 1'b0;
  logic       txTaken, rxValid, selected, readDir, araAnswered, busReset;
  logic       cmdReady, rspValid, rspNack, sclD;
  logic [7:0] rxByte, rspByte, rxLast;
  logic [8:0] sniff;
  int         rxCnt = 0, araCnt = 0, rstCnt = 0, n_fail = 0, checked = 0;

  smbc_bus_if bus ();
  smbc_device #(.TimeoutCyc(ToCyc), .IdleCyc(30), .FiltCyc(FILT_CYC)) u_smbc_device (
    .core_clk(core_clk), .resetn(resetn), .bus(bus), .addrSel(addrSel),
    .alertActive(alertActive), .timeoutEn(timeoutEn), .idleResetEn(idleResetEn),
    .txByte(txByte), .txTaken(txTaken), .rxByte(rxByte), .rxValid(rxValid),
    .selected(selected), .readDir(readDir), .araAnswered(araAnswered), .busReset(busReset));
  smbc_host #(.QtrCyc(20)) u_smbc_host (
    .core_clk(core_clk), .resetn(resetn), .bus(bus), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdByte(cmdByte), .cmdNack(cmdNack), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspByte(rspByte), .rspNack(rspNack));
  smbc_bus_props u_props (
    .core_clk(core_clk), .resetn(resetn), .hostSclOut(bus.hostSclOut),
    .hostSclOe(bus.hostSclOe), .hostSdaOut(bus.hostSdaOut), .hostSdaOe(bus.hostSdaOe),
    .devSdaOut(bus.devSdaOut), .devSdaOe(bus.devSdaOe), .sclLevel(bus.sclLevel),
    .sdaLevel(bus.sdaLevel));

  always #12.5 core_clk = ~core_clk;

  // Sniffs the wire on each clock rise, so the last nine bits hold byte and ninth bit.
  always @(posedge core_clk) begin
    sclD <= bus.sclLevel;
    if (bus.sclLevel === 1'b1 && sclD === 1'b0) sniff <= {sniff[7:0], bus.sdaLevel};
    if (rxValid === 1'b1) rxLast <= rxByte;
    if (rxValid === 1'b1) rxCnt <= rxCnt + 1;
    if (araAnswered === 1'b1) araCnt <= araCnt + 1;
    if (busReset === 1'b1) rstCnt <= rstCnt + 1;
  end

  // Offers the next send byte once the client has taken the current one.
  always @(negedge core_clk) if (txTaken === 1'b1) txByte <= txByte + 8'h11;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1

  // Holds the request until a rising edge sees ready, then waits for completion.
  task automatic hostCmd(input logic [1:0] k, input logic [7:0] b, input logic nk);
    int i;
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdKind = k;
    cmdByte = b;
    cmdNack = nk;
    for (i = 0; cmdReady !== 1'b1 && i < 3000; i++) @(negedge core_clk);
    @(negedge core_clk);
    cmdValid = 1'b0;
    for (i = 0; cmdReady !== 1'b1 && i < 3000; i++) @(negedge core_clk);
    if (i == 3000) n_fail++;
  endtask : hostCmd

  task automatic wr(input logic [7:0] b, input logic nk);
    hostCmd(CMD_WRITE, b, 1'b0);
    chk8(sniff[8:1], b);
    chk1(sniff[0], nk);
    chk1(rspNack, nk);
  endtask : wr

  task automatic rd(input logic [7:0] exp, input logic nk);
    hostCmd(CMD_READ, 8'h00, nk);
    chk8(rspByte, exp);
    chk8(sniff[8:1], exp);
    chk1(sniff[0], nk);
  endtask : rd

  task automatic rst(input logic [2:0] s);
    @(negedge core_clk);
    resetn = 1'b0;
    addrSel = s;
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask : rst

  // Each strap answers only its own address; a stranger's bytes are left alone.
  task automatic t_straps();
    for (int s = 0; s < 8; s++) begin
      rst(3'(s));
      hostCmd(CMD_START, 8'h00, 1'b0);
      wr({ADDR[s], 1'b0}, 1'b0);
      hostCmd(CMD_START, 8'h00, 1'b0);
      wr({ADDR[(s + 1) % 8], 1'b0}, 1'b1);
      wr(8'h3C, 1'b1);
      chk1(selected, 1'b0);
      hostCmd(CMD_STOP, 8'h00, 1'b0);
    end
    chk8(8'(rxCnt), 8'h00);
  endtask : t_straps

  // Write with edge-valued bytes, then stop must free the client.
  task automatic t_write();
    hostCmd(CMD_START, 8'h00, 1'b0);
    wr(8'h30, 1'b0);
    chk1(readDir, 1'b0);
    chk1(selected, 1'b1);
    wr(8'h5A, 1'b0);
    chk8(rxLast, 8'h5A);
    wr(8'h81, 1'b0);
    chk8(rxLast, 8'h81);
    chk8(8'(rxCnt), 8'h02);
    hostCmd(CMD_STOP, 8'h00, 1'b0);
    chk1(selected, 1'b0);
  endtask : t_write

  // Read two bytes, refuse the last, then a repeated start must be heard.
  task automatic t_read();
    txByte = 8'hA5;
    hostCmd(CMD_START, 8'h00, 1'b0);
    wr(8'h31, 1'b0);
    chk1(readDir, 1'b1);
    rd(8'hA5, 1'b0);
    rd(8'hB6, 1'b1);
    hostCmd(CMD_START, 8'h00, 1'b0);
    wr(8'h30, 1'b0);
    chk1(readDir, 1'b0);
    hostCmd(CMD_STOP, 8'h00, 1'b0);
  endtask : t_read

  // Alert response: acked only with the read bit and only while alert is raised.
  task automatic t_ara();
    alertActive = 1'b1;
    hostCmd(CMD_START, 8'h00, 1'b0);
    wr(8'h18, 1'b1);
    hostCmd(CMD_START, 8'h00, 1'b0);
    wr(8'h19, 1'b0);
    rd(8'h30, 1'b1);
    hostCmd(CMD_STOP, 8'h00, 1'b0);
    chk8(8'(araCnt), 8'h01);
    alertActive = 1'b0;
    hostCmd(CMD_START, 8'h00, 1'b0);
    wr(8'h19, 1'b1);
    hostCmd(CMD_STOP, 8'h00, 1'b0);
  endtask : t_ara

  // A held-low clock is harmless until the time-out is switched on.
  task automatic t_timeout();
    hostCmd(CMD_START, 8'h00, 1'b0);
    wr(8'h30, 1'b0);
    repeat (2 * ToCyc) @(negedge core_clk);
    chk1(selected, 1'b1);
    timeoutEn = 1'b1;
    repeat (ToCyc + 20) @(negedge core_clk);
    chk1(selected, 1'b0);
    chk8(8'(rstCnt), 8'h01);
    wr(8'h5A, 1'b1);
    hostCmd(CMD_STOP, 8'h00, 1'b0);
    timeoutEn = 1'b0;
  endtask : t_timeout

  // The shortened idle limit is below one clock-high phase, so a one bit trips it.
  task automatic t_idle();
    idleResetEn = 1'b1;
    hostCmd(CMD_START, 8'h00, 1'b0);
    wr(8'h30, 1'b1);
    chk8(8'(rstCnt), 8'h02);
    chk1(selected, 1'b0);
    hostCmd(CMD_STOP, 8'h00, 1'b0);
    idleResetEn = 1'b0;
  endtask : t_idle

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  initial begin
    t_straps();
    t_write();
    t_read();
    t_ara();
    t_timeout();
    t_idle();
    summarize();
  end

  // The tests need about 31000 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (70000) @(posedge core_clk);
    n_fail++;
    summarize();
  end
endmodule : tb
